// File: design/aou_fifo.sv
// output sample fifo, flip-flop storage
`timescale 1ns/1ps
`default_nettype none
module aou_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 32,
    parameter int LW = 6
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    aou_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || LW < AW + 1) begin : g_chk
            $error("fifo depth must be a power of two, level wide enough");
        end
    endgenerate

    logic [W-1:0] mem_ff [DEPTH];
    logic [W-1:0] nxt_mem [DEPTH];
    logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [LW-1:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy;
    logic push, pop;

    assign push = f.in_valid && rdy_ff;
    assign pop = f.out_ready && (cnt_ff != '0);
    assign f.in_ready = rdy_ff;
    assign f.out_valid = (cnt_ff != '0);
    assign f.out_data = mem_ff[rp_ff];
    assign f.level = cnt_ff;

    always_comb begin
        nxt_mem = mem_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wp_ff] = f.in_data;
            nxt_wp = wp_ff + 1'b1;
        end
        if (pop) begin
            nxt_rp = rp_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        // ready is registered so back-pressure leaves from a flop
        nxt_rdy = (nxt_cnt != LW'(DEPTH));
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b1;
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
            mem_ff <= nxt_mem;
        end
    end

    a_fifo_count: assert property (
        @(posedge mclk_in) disable iff (rst_in)
        push && !pop |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("fifo level did not count a push");
    a_fifo_full: assert property (
        @(posedge mclk_in) disable iff (rst_in)
        cnt_ff == LW'(DEPTH) |-> !rdy_ff)
        else $error("fifo ready while full");
endmodule : aou_fifo
`default_nettype wire

// File: design/aou_fifo_if.sv
// carrier between the update controller and its output fifo
`timescale 1ns/1ps
`default_nettype none
interface aou_fifo_if #(parameter int W = 16, parameter int LW = 6);
    logic in_valid;
    logic [W-1:0] in_data;
    logic in_ready;
    logic out_valid;
    logic [W-1:0] out_data;
    logic out_ready;
    logic [LW-1:0] level;
    modport fifo (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data, level);
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data, level);
endinterface : aou_fifo_if
`default_nettype wire

// File: design/aou_pkg.sv
// types of the analog output update control block
package aou_pkg;
    typedef enum logic [1:0] {
        AOU_FIXED, AOU_RATEGEN, AOU_SOFT, AOU_HARD
    } aou_mode_e;
    typedef enum logic [1:0] {
        AOU_DMA_OFF, AOU_DMA_BLOCK, AOU_DMA_DEMAND
    } aou_dma_e;
    typedef enum logic {
        AOU_POP_CHAN, AOU_POP_VAL
    } aou_pop_e;
endpackage : aou_pkg

// File: design/aou_regs.svh
// constants of the analog output update control block
`ifndef AOU_REGS_SVH
`define AOU_REGS_SVH
`define AOU_CLK_HZ 20000000
`define AOU_AGG_RATE_HZ 250000
`define AOU_MIN_STROBE_HZ 305
// least spacing of channel updates, rounded up to whole cycles
`define AOU_UPD_CYC ((`AOU_CLK_HZ + `AOU_AGG_RATE_HZ - 1) / `AOU_AGG_RATE_HZ)
// longest strobe period, rounded down
`define AOU_MAX_DIV (`AOU_CLK_HZ / `AOU_MIN_STROBE_HZ)
`define AOU_NCH 8
`define AOU_WORD_W 16
`define AOU_HOST_W 32
`define AOU_FIFO_DEPTH 32
`define AOU_AE_LEVEL 8
`define AOU_DIV_W 17
`endif

// File: design/aou_update_ctrl.sv
// analog output update control: fifo unpacking and update strobes
`timescale 1ns/1ps
`default_nettype none
`include "aou_regs.svh"
module aou_update_ctrl #(
    parameter int NCH = `AOU_NCH,
    parameter int DEPTH = `AOU_FIFO_DEPTH,
    parameter int AE_LEVEL = `AOU_AE_LEVEL,
    parameter int MAX_DIV = `AOU_MAX_DIV,
    parameter int UPD_CYC = `AOU_UPD_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [`AOU_HOST_W-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire aou_pkg::aou_mode_e mode_in,
    input wire logic [3:0] active_chan_in,
    input wire logic [`AOU_DIV_W-1:0] rate_div_in,
    input wire logic sw_strobe_in,
    input wire logic ext_strobe_in,
    output logic update_strobe_ready_out,
    input wire logic [1:0] irq_sel_in,
    output logic irq_out,
    output logic fifo_full_out,
    output logic fifo_almost_empty_out,
    input wire aou_pkg::aou_dma_e dma_mode_in,
    input wire logic [1:0] dma_chan_en_in,
    output logic [1:0] dma_req_out,
    output logic [NCH*`AOU_WORD_W-1:0] dac_data_out,
    output logic dac_load_out
);
    localparam int WW = `AOU_WORD_W;
    localparam int LW = $clog2(DEPTH) + 1;
    localparam int DW = `AOU_DIV_W;
    localparam int CW = $clog2(NCH);
    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    generate
        if (NCH < 2 || NCH > 8 || (1 << CW) != NCH || MAX_DIV < 2 ||
            MAX_DIV >= (1 << DW) || UPD_CYC * NCH > MAX_DIV ||
            UPD_CYC < 1 || UPD_CYC >= (1 << 12) ||
            AE_LEVEL >= DEPTH) begin : g_chk
            $error("unsupported channel count, divider or threshold");
        end
    endgenerate

    aou_fifo_if #(.W(WW), .LW(LW)) fq ();
    aou_fifo #(.W(WW), .DEPTH(DEPTH), .LW(LW)) u_fifo (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .f(fq)
    );

    ////////////////////////////////////////////////////////////////////////
    // state
    aou_pkg::aou_pop_e pop_ff, nxt_pop;
    logic [CW-1:0] chan_ff, nxt_chan;
    logic [11:0] pace_ff, nxt_pace;
    logic [11:0] gap_ff, nxt_gap;
    logic [DW-1:0] rg_ff, nxt_rg, period, min_div, reload;
    logic [3:0] act;
    logic [WW-1:0] pend_ff [NCH];
    logic [WW-1:0] nxt_pend [NCH];
    logic [WW-1:0] dac_ff [NCH];
    logic [WW-1:0] nxt_dac [NCH];
    logic s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
    logic ext_rise, rg_tick, upd, pop_val, pop_chan;
    logic load_ff, nxt_load, srdy_ff, nxt_srdy, irq_ff, nxt_irq;
    logic full_ff, nxt_full, ae_ff, nxt_ae;
    logic [1:0] dreq_ff, nxt_dreq;

    // one fifo entry per 32-bit host write, low half
    assign fq.in_valid = wr_valid_in;
    assign fq.in_data = wr_data_in[WW-1:0];
    // value entries wait for the pacing count
    assign fq.out_ready = (pop_ff == aou_pkg::AOU_POP_CHAN) || (pace_ff == '0);
    assign pop_chan = fq.out_valid && (pop_ff == aou_pkg::AOU_POP_CHAN);
    assign pop_val = fq.out_valid && fq.out_ready &&
                     (pop_ff == aou_pkg::AOU_POP_VAL);

    ////////////////////////////////////////////////////////////////////////
    // strobe timing
    assign act = (active_chan_in == '0) ? 4'h1 :
                 (active_chan_in > 4'(NCH)) ? 4'(NCH) : active_chan_in;
    assign min_div = DW'(UPD_CYC) * DW'(act);
    // clamp programmed period into the legal range
    assign period = (rate_div_in < min_div) ? min_div :
                    (rate_div_in > DW'(MAX_DIV)) ? DW'(MAX_DIV) : rate_div_in;
    // fixed mode ignores the programmed divider
    assign reload = (mode_in == aou_pkg::AOU_FIXED) ? min_div : period;
    assign rg_tick = (rg_ff == '0);
    // edge counts once second and third stage agree
    assign ext_rise = (s2_ff == s3_ff) && s3_ff && !lvl_ff;

    always_comb begin
        upd = 1'b0;
        case (mode_in)
            // fixed mode strobes at maximum rate per active channel
            aou_pkg::AOU_FIXED: upd = rg_tick;
            // rate generator strobe loads every channel
            aou_pkg::AOU_RATEGEN: upd = rg_tick;
            aou_pkg::AOU_SOFT: upd = sw_strobe_in;
            aou_pkg::AOU_HARD: upd = ext_rise && srdy_ff;
            default: upd = 1'b0;
        endcase
    end

    always_comb begin
        nxt_pop = pop_ff;
        nxt_chan = chan_ff;
        nxt_pace = (pace_ff != '0) ? pace_ff - 1'b1 : pace_ff;
        nxt_pend = pend_ff;
        // cycles since the last value pop, saturating, for the pacing check
        nxt_gap = pop_val ? 12'h001 : (gap_ff == '1) ? gap_ff : gap_ff + 1'b1;
        case (pop_ff)
            // first entry of a pair names the channel
            aou_pkg::AOU_POP_CHAN: begin
                if (pop_chan) begin
                    nxt_chan = fq.out_data[CW-1:0];
                    nxt_pop = aou_pkg::AOU_POP_VAL;
                end
            end
            aou_pkg::AOU_POP_VAL: begin
                if (pop_val) begin
                    nxt_pend[chan_ff] = fq.out_data;
                    nxt_pace = 12'(UPD_CYC - 1);
                    nxt_pop = aou_pkg::AOU_POP_CHAN;
                end
            end
            default: nxt_pop = aou_pkg::AOU_POP_CHAN;
        endcase
    end

    always_comb begin
        nxt_rg = (rg_tick || mode_in == aou_pkg::AOU_SOFT ||
                  mode_in == aou_pkg::AOU_HARD) ? reload - 1'b1 : rg_ff - 1'b1;
        nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
        nxt_dac = dac_ff;
        // all channels copied in one cycle; a value arriving now waits
        if (upd) begin
            nxt_dac = pend_ff;
        end
        nxt_load = upd;
        // ready in hardware mode, not in the cycle of a load
        nxt_srdy = (mode_in == aou_pkg::AOU_HARD) && !upd && !load_ff;
        nxt_full = !fq.in_ready;
        nxt_ae = (fq.level <= LW'(AE_LEVEL));
        // each flag gated by its own select bit; one output
        nxt_irq = (irq_sel_in[0] && !fq.in_ready) ||
                  (irq_sel_in[1] && (fq.level <= LW'(AE_LEVEL)));
        nxt_dreq = 2'b00;
        // block uses channel 0; demand channels ask when running low
        case (dma_mode_in)
            aou_pkg::AOU_DMA_BLOCK: nxt_dreq = {1'b0, fq.in_ready};
            aou_pkg::AOU_DMA_DEMAND:
                nxt_dreq = dma_chan_en_in &
                           {2{fq.in_ready && (fq.level <= LW'(AE_LEVEL))}};
            default: nxt_dreq = 2'b00;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pop_ff <= aou_pkg::AOU_POP_CHAN;
            chan_ff <= '0;
            pace_ff <= '0;
            gap_ff <= '1;
            rg_ff <= '0;
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            lvl_ff <= 1'b0;
            load_ff <= 1'b0;
            srdy_ff <= 1'b0;
            irq_ff <= 1'b0;
            full_ff <= 1'b0;
            ae_ff <= 1'b0;
            dreq_ff <= 2'b00;
        end else begin
            pop_ff <= nxt_pop;
            chan_ff <= nxt_chan;
            pace_ff <= nxt_pace;
            gap_ff <= nxt_gap;
            rg_ff <= nxt_rg;
            s1_ff <= ext_strobe_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
            load_ff <= nxt_load;
            srdy_ff <= nxt_srdy;
            irq_ff <= nxt_irq;
            full_ff <= nxt_full;
            ae_ff <= nxt_ae;
            dreq_ff <= nxt_dreq;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_ff @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    pend_ff[g] <= '0;
                    dac_ff[g] <= '0;
                end else begin
                    pend_ff[g] <= nxt_pend[g];
                    dac_ff[g] <= nxt_dac[g];
                end
            end
            assign dac_data_out[g*WW +: WW] = dac_ff[g];
        end
    endgenerate

    assign wr_ready_out = fq.in_ready;
    assign update_strobe_ready_out = srdy_ff;
    assign irq_out = irq_ff;
    assign fifo_full_out = full_ff;
    assign fifo_almost_empty_out = ae_ff;
    assign dma_req_out = dreq_ff;
    assign dac_load_out = load_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_hw_edge;
        mode_in == aou_pkg::AOU_HARD && srdy_ff ##0 ext_rise;
    endsequence
    sequence s_load_seen;
        ##1 dac_load_out && dac_data_out[WW-1:0] == $past(pend_ff[0]);
    endsequence

    a_soft_load: assert property (
        mode_in == aou_pkg::AOU_SOFT && sw_strobe_in |=> dac_load_out)
        else $error("software strobe gave no load");
    a_hw_edge_load: assert property (
        s_hw_edge |-> s_load_seen)
        else $error("external strobe did not load channels");
    a_hw_not_ready: assert property (
        mode_in == aou_pkg::AOU_HARD && !srdy_ff |=> !dac_load_out)
        else $error("strobe taken while not ready");
    a_ready_mode: assert property (
        update_strobe_ready_out |-> $past(mode_in) == aou_pkg::AOU_HARD)
        else $error("strobe ready outside hardware mode");
    a_rg_reload: assert property (
        mode_in == aou_pkg::AOU_RATEGEN && rg_tick
        |=> rg_ff == $past(period) - 1'b1)
        else $error("rate generator reload wrong");
    a_fixed_reload: assert property (
        mode_in == aou_pkg::AOU_FIXED && rg_tick
        |=> rg_ff == $past(min_div) - 1'b1)
        else $error("fixed rate reload wrong");
    a_rg_bounds: assert property (
        period >= min_div && period <= DW'(MAX_DIV))
        else $error("strobe period out of range");
    a_tick_load: assert property (
        (mode_in == aou_pkg::AOU_RATEGEN || mode_in == aou_pkg::AOU_FIXED)
        && rg_tick |-> s_load_seen)
        else $error("timed strobe did not load");
    a_pace_gap: assert property (
        pop_val |-> gap_ff >= 12'(UPD_CYC))
        else $error("values drained too fast");
    a_pair_order: assert property (
        pop_chan |=> pop_ff == aou_pkg::AOU_POP_VAL)
        else $error("channel not followed by value");
    a_irq_full: assert property (
        irq_sel_in[0] && !fq.in_ready |=> irq_out)
        else $error("full interrupt missing");
endmodule : aou_update_ctrl
`default_nettype wire

// File: sim/analog_output_update_control_tb.sv
// self-checking bench for the analog output update controller
`timescale 1ns/1ps
`default_nettype none
module analog_output_update_control_tb;
    localparam int UPD = 4;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr_valid, wr_ready, sw_strobe, ext_strobe, strb_rdy, irq, full, ae;
    logic dac_load;
    logic [31:0] wr_data;
    logic [3:0] act = 4'h1;
    logic [16:0] div = 17'h0_0032;
    logic [1:0] irq_sel = 2'h0, dma_en = 2'h0, dma_req;
    logic [127:0] dac_data, exp;
    aou_pkg::aou_mode_e mode = aou_pkg::AOU_SOFT;
    aou_pkg::aou_dma_e dma_mode = aou_pkg::AOU_DMA_OFF;
    int errors = 0;
    int compares = 0;
    logic saw_full, saw_irq;
    always #25 mclk_in = ~mclk_in;
    initial begin
        sw_strobe = 1'b0;
        ext_strobe = 1'b0;
    end
    aou_update_ctrl #(.MAX_DIV(1000), .UPD_CYC(UPD)) u_dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .wr_data_in(wr_data),
        .wr_valid_in(wr_valid), .wr_ready_out(wr_ready), .mode_in(mode),
        .active_chan_in(act), .rate_div_in(div), .sw_strobe_in(sw_strobe),
        .ext_strobe_in(ext_strobe), .update_strobe_ready_out(strb_rdy),
        .irq_sel_in(irq_sel), .irq_out(irq), .fifo_full_out(full),
        .fifo_almost_empty_out(ae), .dma_mode_in(dma_mode),
        .dma_chan_en_in(dma_en), .dma_req_out(dma_req),
        .dac_data_out(dac_data), .dac_load_out(dac_load));
    aou_host_model u_host (.mclk_in(mclk_in), .wr_ready_in(wr_ready),
        .wr_valid_out(wr_valid), .wr_data_out(wr_data));
    always @(posedge mclk_in) begin
        if (full === 1'b1) saw_full <= 1'b1;
        if (irq === 1'b1) saw_irq <= 1'b1;
    end
    task automatic check(input logic [127:0] got, input logic [127:0] e);
        compares++;
        if (got !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in) #1;
    endtask : step
    task automatic wait_load(output int n);
        n = 0;
        while (dac_load !== 1'b1 && n < 2000) begin
            step(1);
            n++;
        end
        check(n < 2000, 1'b1);
    endtask : wait_load
    ////////////////////////////////////////////////////////////////////////
    task automatic t_soft();
        logic [15:0] v;
        for (int ch = 0; ch < 8; ch++) begin
            v = 16'h1000 + 16'(ch) * 16'h0111;
            exp[ch*16 +: 16] = v;
            // upper half is junk on purpose: only the low half is an entry
            u_host.put_pair({16'ha5a5, 16'(ch)}, {16'hffff, v});
        end
        u_host.idle();
        step(60);
        check(dac_data, 128'h0);
        sw_strobe = 1'b1;
        step(1);
        sw_strobe = 1'b0;
        check(dac_load, 1'b1);
        check(dac_data, exp);
        step(1);
        check(dac_load, 1'b0);
        $display("test soft strobe done");
    endtask : t_soft
    task automatic t_hard();
        int n;
        mode = aou_pkg::AOU_HARD;
        u_host.put_pair(32'h0000_0003, 32'h0000_7e57);
        u_host.idle();
        exp[63:48] = 16'h7e57;
        step(30);
        check(strb_rdy, 1'b1);
        sw_strobe = 1'b1;
        step(1);
        sw_strobe = 1'b0;
        for (int i = 0; i < 4; i++) begin
            check(dac_load, 1'b0);
            step(1);
        end
        ext_strobe = 1'b1;
        wait_load(n);
        check(n <= 6, 1'b1);
        check(dac_data, exp);
        ext_strobe = 1'b0;
        step(6);
        check(strb_rdy, 1'b1);
        $display("test hard strobe done");
    endtask : t_hard
    task automatic t_rate(input aou_pkg::aou_mode_e m, input logic [3:0] a,
                          input logic [16:0] d, input int per);
        int n;
        mode = m;
        act = a;
        div = d;
        wait_load(n);
        step(1);
        wait_load(n);
        step(1);
        wait_load(n);
        check(n + 1, per);
        $display("test rate period %0d done", per);
    endtask : t_rate
    task automatic t_fill();
        saw_full = 1'b0;
        saw_irq = 1'b0;
        mode = aou_pkg::AOU_SOFT;
        irq_sel = 2'h1;
        // writes come every cycle, pairs drain one per UPD cycles: net gain
        // is about half an entry a cycle, so 96 entries overrun 32 slots
        for (int i = 0; i < 48; i++) u_host.put_pair(32'h0, 32'(i));
        u_host.idle();
        check(saw_full, 1'b1);
        check(saw_irq, 1'b1);
        step(300);
        check({ae, full, irq}, 3'b100);
        irq_sel = 2'h2;
        step(3);
        check(irq, 1'b1);
        dma_mode = aou_pkg::AOU_DMA_BLOCK;
        step(3);
        check(dma_req, 2'h1);
        dma_mode = aou_pkg::AOU_DMA_DEMAND;
        dma_en = 2'h2;
        step(3);
        check(dma_req, 2'h2);
        $display("test fifo flags done");
    endtask : t_fill
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    initial begin
        exp = 128'h0;
        step(16);
        rst_in = 1'b0;
        step(2);
        check({wr_ready, full, dac_data}, {2'b10, 128'h0});
        t_soft();
        t_hard();
        t_rate(aou_pkg::AOU_RATEGEN, 4'h1, 17'h0_0032, 50);
        t_rate(aou_pkg::AOU_RATEGEN, 4'h8, 17'h0_0002, 32);
        t_rate(aou_pkg::AOU_RATEGEN, 4'h1, 17'h0_07d0, 1000);
        t_rate(aou_pkg::AOU_FIXED, 4'h3, 17'h0_0032, 12);
        t_rate(aou_pkg::AOU_FIXED, 4'h0, 17'h0_0000, UPD);
        t_fill();
        close_out();
    end
    initial begin
        #(30000 * 50);
        errors++;
        close_out();
    end
endmodule : analog_output_update_control_tb
`default_nettype wire

// File: sim/aou_host_model.sv
// host side model: hands channel and value words to the output fifo
`timescale 1ns/1ps
`default_nettype none
module aou_host_model (
    input wire logic mclk_in,
    input wire logic wr_ready_in,
    output logic wr_valid_out,
    output logic [31:0] wr_data_out
);
    initial begin
        wr_valid_out = 1'b0;
        wr_data_out = 32'hffff_ffff;
    end
    // ready is registered, so its level at the falling edge holds at the next
    // rising edge; sampling there avoids racing the design's own update
    task automatic put(input logic [31:0] w);
        wr_valid_out = 1'b1;
        wr_data_out = w;
        @(negedge mclk_in);
        while (wr_ready_in !== 1'b1) @(negedge mclk_in);
        @(posedge mclk_in) #1;
    endtask : put
    task automatic put_pair(input logic [31:0] c, input logic [31:0] v);
        put(c);
        put(v);
    endtask : put_pair
    // released lines show the inverse of the last word
    task automatic idle();
        wr_valid_out = 1'b0;
        wr_data_out = ~wr_data_out;
    endtask : idle
endmodule : aou_host_model
`default_nettype wire
